// ---- hdl/tpcg_pkg.sv ----
// tpcg_pkg: register map, field layout, reset values and pattern style codes
package tpcg_pkg;
   // ==========================================================
   // register offsets
   localparam logic [7:0] OFS_STYLE = 8'h0A;
   localparam logic [7:0] OFS_LANE = 8'h0B;
   localparam logic [7:0] OFS_CHK_HIGH = 8'h0C;
   localparam logic [7:0] OFS_CHK_LOW = 8'h0D;
   localparam logic [7:0] OFS_CHK_REF = 8'h0E;
   localparam logic [7:0] OFS_INJECT = 8'h0F;
   localparam logic [7:0] OFS_TALLY_LO = 8'h10;
   localparam logic [7:0] OFS_TALLY_HI = 8'h11;
   localparam logic [7:0] OFS_GEN_BYTE = 8'h12;
   localparam logic [7:0] OFS_STATUS = 8'h1F;
   // ==========================================================
   // field layout
   localparam int SLOT_W = 7;
   localparam int LANE_W = 5;
   localparam int STYLE_W = 4;
   localparam int TALLY_W = 16;
   localparam int GEN_STYLE_LSB = 4;
   localparam int CHK_STYLE_LSB = 0;
   localparam int DONE_BIT = 0;
   // ==========================================================
   // reset values
   localparam logic [7:0] RST_BYTE = 8'h00;
   localparam logic [SLOT_W-1:0] RST_SLOT = 7'h00;
   localparam logic [LANE_W-1:0] RST_LANE = 5'h00;
   localparam logic [TALLY_W-1:0] RST_TALLY = 16'h0000;
   localparam logic [TALLY_W-1:0] TALLY_MAX = 16'hFFFF;
   // ==========================================================
   // pattern styles and pseudo-random sequence
   localparam logic [STYLE_W-1:0] STYLE_MARK = 4'h0;
   localparam logic [STYLE_W-1:0] STYLE_ALT = 4'hC;
   localparam logic [STYLE_W-1:0] STYLE_FIXED = 4'hF;
   localparam int PRBS_LEN = 11;
   localparam int TAP_A = 10;
   localparam int TAP_B = 8;
   localparam logic [PRBS_LEN-1:0] PRBS_SEED = 11'h7FF;
endpackage : tpcg_pkg

// ---- hdl/tpcg_pat_if.sv ----
// tpcg_pat_if: request and answer between a pattern user and the pattern engine
`timescale 1ns/10ps
interface tpcg_pat_if;
   import tpcg_pkg::*;
   logic [STYLE_W-1:0] style;
   logic [7:0] user_byte;
   logic [2:0] bit_idx;
   logic [PRBS_LEN-1:0] hist;
   logic expect_bit;
   modport client (output style, output user_byte, output bit_idx, output hist,
      input expect_bit);
   modport engine (input style, input user_byte, input bit_idx, input hist,
      output expect_bit);
endinterface : tpcg_pat_if

// ---- hdl/tpcg_pattern.sv ----
// tpcg_pattern: expected pattern bit for a given style and bit position
`timescale 1ns/10ps
module tpcg_pattern import tpcg_pkg::*; (
   tpcg_pat_if.engine p
);
   // ==========================================================
   // pattern select
   always_comb begin
      case (p.style)
         STYLE_MARK: p.expect_bit = 1'b1;
         STYLE_ALT: p.expect_bit = ~p.bit_idx[0];
         // user byte sent msb first
         STYLE_FIXED: p.expect_bit = p.user_byte[3'h7 - p.bit_idx];
         // one shared sequence stands in for every pseudo-random style
         default: p.expect_bit = p.hist[TAP_A] ^ p.hist[TAP_B];
      endcase
   end
endmodule : tpcg_pattern

// ---- hdl/tpcg_unit.sv ----
// tpcg_unit: test-pattern checker, generator, error injection and tally
`timescale 1ns/10ps
module tpcg_unit import tpcg_pkg::*; #(
   parameter int NUM_LANES = 32
) (
   input wire logic ref_clk,
   input wire logic rst,
   input wire logic [7:0] host_addr,
   input wire logic host_wr,
   input wire logic host_rd,
   input wire logic [7:0] host_wdata,
   input wire logic hw_bit_clk,
   input wire logic hw_frame,
   input wire logic [NUM_LANES-1:0] rx_lanes,
   output logic [7:0] host_rdata,
   output logic tx_bit,
   output logic inject_done
);
   // ==========================================================
   // pin synchronisers
   logic clk_s1, clk_s2, clk_s3;
   logic frame_s1, frame_s2;
   logic [NUM_LANES-1:0] lanes_s1, lanes_s2;

   always_ff @(posedge ref_clk) begin
      if (rst) begin
         clk_s1 <= 1'b0;
         clk_s2 <= 1'b0;
         clk_s3 <= 1'b0;
         frame_s1 <= 1'b0;
         frame_s2 <= 1'b0;
         lanes_s1 <= '0;
         lanes_s2 <= '0;
      end else begin
         clk_s1 <= hw_bit_clk;
         clk_s2 <= clk_s1;
         clk_s3 <= clk_s2;
         frame_s1 <= hw_frame;
         frame_s2 <= frame_s1;
         lanes_s1 <= rx_lanes;
         lanes_s2 <= lanes_s1;
      end
   end

   // bit sampled on rising highway clock edge
   logic tick;
   assign tick = clk_s2 & ~clk_s3;

   // ==========================================================
   // state
   logic [7:0] style, chk_ref, gen_byte, inject;
   logic [LANE_W-1:0] lane;
   logic [SLOT_W-1:0] chk_low, chk_high, slot;
   logic [2:0] bit_idx;
   logic [TALLY_W-1:0] tally, snap;
   logic [PRBS_LEN-1:0] gen_hist, chk_hist;
   logic [7:0] next_style, next_chk_ref, next_gen_byte, next_inject, next_host_rdata;
   logic [LANE_W-1:0] next_lane;
   logic [SLOT_W-1:0] next_chk_low, next_chk_high, next_slot;
   logic [2:0] next_bit_idx;
   logic [TALLY_W-1:0] next_tally, next_snap;
   logic [PRBS_LEN-1:0] next_gen_hist, next_chk_hist;
   logic next_tx_bit, next_inject_done;

   // ==========================================================
   // pattern engines
   tpcg_pat_if gen_if ();
   tpcg_pat_if chk_if ();
   logic [2:0] cur_bit;
   logic [SLOT_W-1:0] cur_slot;

   assign cur_bit = frame_s2 ? 3'h0 : bit_idx;
   assign cur_slot = frame_s2 ? RST_SLOT : slot;
   assign gen_if.style = style[GEN_STYLE_LSB +: STYLE_W];
   assign gen_if.user_byte = gen_byte;
   assign gen_if.bit_idx = cur_bit;
   assign gen_if.hist = gen_hist;
   assign chk_if.style = style[CHK_STYLE_LSB +: STYLE_W];
   assign chk_if.user_byte = chk_ref;
   assign chk_if.bit_idx = cur_bit;
   assign chk_if.hist = chk_hist;

   tpcg_pattern u_gen (.p(gen_if.engine));
   tpcg_pattern u_chk (.p(chk_if.engine));

   // ==========================================================
   // datapath terms
   logic in_window, chk_on, rx_now, mismatch, rd_low, wr_inj, inj_go, finish;

   // no wrap-around window; lower above upper checks nothing
   assign in_window = (cur_slot >= chk_low) && (cur_slot <= chk_high);
   assign chk_on = tick && in_window;
   assign rx_now = lanes_s2[lane];
   assign mismatch = chk_on && (rx_now != chk_if.expect_bit);
   assign rd_low = host_rd && (host_addr == OFS_TALLY_LO);
   assign wr_inj = host_wr && (host_addr == OFS_INJECT);
   // only on bit 0 of a slot, so one error per slot at most
   assign inj_go = tick && (cur_bit == 3'h0) && (inject != RST_BYTE) && !wr_inj;
   assign finish = inj_go && (inject == 8'h01);

   // ==========================================================
   // next-state
   always_comb begin
      next_style = style;
      next_lane = lane;
      next_chk_high = chk_high;
      next_chk_low = chk_low;
      next_chk_ref = chk_ref;
      next_gen_byte = gen_byte;
      next_inject = inject;
      next_host_rdata = host_rdata;
      next_bit_idx = bit_idx;
      next_slot = slot;
      next_gen_hist = gen_hist;
      next_chk_hist = chk_hist;
      next_tx_bit = tx_bit;
      next_snap = snap;
      // a new count written in the same cycle beats the decrement
      if (wr_inj) begin
         next_inject = host_wdata;
      end else if (inj_go) begin
         next_inject = inject - 8'h01;
      end
      if (host_wr) begin
         case (host_addr)
            OFS_STYLE: next_style = host_wdata;
            OFS_LANE: next_lane = host_wdata[LANE_W-1:0];
            OFS_CHK_HIGH: next_chk_high = host_wdata[SLOT_W-1:0];
            OFS_CHK_LOW: next_chk_low = host_wdata[SLOT_W-1:0];
            OFS_CHK_REF: next_chk_ref = host_wdata;
            OFS_GEN_BYTE: next_gen_byte = host_wdata;
            default: next_style = style;
         endcase
      end
      if (host_rd) begin
         case (host_addr)
            OFS_STYLE: next_host_rdata = style;
            OFS_LANE: next_host_rdata = {3'h0, lane};
            OFS_CHK_HIGH: next_host_rdata = {1'b0, chk_high};
            OFS_CHK_LOW: next_host_rdata = {1'b0, chk_low};
            OFS_CHK_REF: next_host_rdata = chk_ref;
            OFS_INJECT: next_host_rdata = inject;
            OFS_TALLY_LO: next_host_rdata = tally[7:0];
            OFS_TALLY_HI: next_host_rdata = snap[15:8];
            OFS_GEN_BYTE: next_host_rdata = gen_byte;
            OFS_STATUS: next_host_rdata = {7'h00, inject_done};
            default: next_host_rdata = RST_BYTE;
         endcase
      end
      // low read latches the whole count; mismatch this cycle starts the new one
      if (rd_low) begin
         next_snap = tally;
         next_tally = {{(TALLY_W-1){1'b0}}, mismatch};
      end else if (mismatch && tally != TALLY_MAX) begin
         next_tally = tally + 16'h0001;
      end else begin
         next_tally = tally;
      end
      if (tick) begin
         next_bit_idx = cur_bit + 3'h1;
         next_slot = (cur_bit == 3'h7) ? cur_slot + 7'h01 : cur_slot;
         next_gen_hist = {gen_hist[PRBS_LEN-2:0], gen_if.expect_bit};
         next_tx_bit = gen_if.expect_bit ^ inj_go;
      end
      if (chk_on) begin
         next_chk_hist = {chk_hist[PRBS_LEN-2:0], rx_now};
      end
      // completion wins over a clear in the same cycle
      next_inject_done = finish ||
         (inject_done && !(host_wr && host_addr == OFS_STATUS && host_wdata[DONE_BIT]));
   end

   always_ff @(posedge ref_clk) begin
      if (rst) begin
         style <= RST_BYTE;
         lane <= RST_LANE;
         chk_high <= RST_SLOT;
         chk_low <= RST_SLOT;
         chk_ref <= RST_BYTE;
         gen_byte <= RST_BYTE;
         inject <= RST_BYTE;
         host_rdata <= RST_BYTE;
         bit_idx <= 3'h0;
         slot <= RST_SLOT;
         gen_hist <= PRBS_SEED;
         chk_hist <= PRBS_SEED;
         tx_bit <= 1'b1;
         tally <= RST_TALLY;
         snap <= RST_TALLY;
         inject_done <= 1'b0;
      end else begin
         style <= next_style;
         lane <= next_lane;
         chk_high <= next_chk_high;
         chk_low <= next_chk_low;
         chk_ref <= next_chk_ref;
         gen_byte <= next_gen_byte;
         inject <= next_inject;
         host_rdata <= next_host_rdata;
         bit_idx <= next_bit_idx;
         slot <= next_slot;
         gen_hist <= next_gen_hist;
         chk_hist <= next_chk_hist;
         tx_bit <= next_tx_bit;
         tally <= next_tally;
         snap <= next_snap;
         inject_done <= next_inject_done;
      end
   end

   // ==========================================================
   // assertions
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (rst);

   sequence read_low_s;
      rd_low;
   endsequence
   sequence read_high_s;
      host_rd && (host_addr == OFS_TALLY_HI);
   endsequence
   sequence last_inject_s;
      inj_go && (inject == 8'h01);
   endsequence

   inject_step_a: assert property (inj_go |=> inject == $past(inject) - 8'h01)
      else $error("injection count did not step down");
   inject_done_a: assert property (last_inject_s |=> inject_done && inject == RST_BYTE)
      else $error("done flag or cleared count missing after last injection");
   one_per_slot_a: assert property (inj_go |-> cur_bit == 3'h0 ##1 !inj_go)
      else $error("error injected off slot start");
   inject_flip_a: assert property (inj_go |=> tx_bit != $past(gen_if.expect_bit))
      else $error("injected bit not inverted");
   tally_count_a: assert property (mismatch && !rd_low && tally != TALLY_MAX
      |=> tally == $past(tally) + 16'h0001)
      else $error("mismatch not counted");
   outside_window_a: assert property (tick && (cur_slot < chk_low || cur_slot > chk_high)
      && !rd_low |=> tally == $past(tally))
      else $error("slot outside window counted");
   tally_latch_a: assert property (read_low_s |=> snap == $past(tally)
      && tally == {15'h0000, $past(mismatch)})
      else $error("low read did not latch and restart tally");
   // spacing of three cycles matches a host that reads low and high one access apart
   tally_pair_a: assert property (read_low_s ##1 (!rd_low)[*3] ##0 read_high_s
      |=> host_rdata == $past(tally, 4) >> 8)
      else $error("high byte does not pair with low read");
   fixed_tx_a: assert property (tick && gen_if.style == STYLE_FIXED && !inj_go
      |=> tx_bit == $past(gen_byte[3'h7 - cur_bit]))
      else $error("fixed generator byte not sent");
   fixed_chk_a: assert property (chk_on && chk_if.style == STYLE_FIXED && !rd_low
      && rx_now != chk_ref[3'h7 - cur_bit] && tally != TALLY_MAX
      |=> tally == $past(tally) + 16'h0001)
      else $error("reference byte mismatch not counted");
endmodule : tpcg_unit

// ---- verification/tpcg_hw_model.sv ----
// tpcg_hw_model: far side of the highway, makes bit clock, frame and lanes, watches tx
`timescale 1ns/10ps
module tpcg_hw_model #(
   parameter int SLOTS = 32,
   parameter int NUM_LANES = 32
) (
   input wire logic ref_clk,
   input wire logic rst,
   input wire logic [4:0] lane,
   input wire logic [7:0] rx_byte,
   input wire logic [7:0] gen_byte,
   input wire logic tx_bit,
   output logic hw_bit_clk = 1'b0,
   output logic hw_frame = 1'b0,
   output logic [NUM_LANES-1:0] rx_lanes = '0,
   output int tx_errs,
   output int multi
);
   // ==========================================================
   // bit timing
   // eight ref_clk per bit; data moves on the falling bit edge, so it is settled at the rise
   int ph;
   int pos;
   int serr;
   int nb;
   int e;
   logic [NUM_LANES-1:0] v;
   always @(posedge ref_clk) begin
      if (rst) begin
         ph <= 0;
         pos <= SLOTS * 8 - 1;
         serr <= 0;
         tx_errs <= 0;
         multi <= 0;
         // first bit after reset is slot 0 bit 0, so it must carry real data and frame
         v = {NUM_LANES{~rx_byte[7]}};
         v[lane] = rx_byte[7];
         hw_frame <= 1'b1;
         rx_lanes <= v;
      end else begin
         ph <= (ph + 1) % 8;
         if (ph == 0) begin
            hw_bit_clk <= 1'b1;
            pos <= (pos + 1) % (SLOTS * 8);
         end
         if (ph == 4) begin
            nb = (pos + 1) % (SLOTS * 8);
            // unselected lanes carry the inverse, so a wrong lane choice shows up
            v = {NUM_LANES{~rx_byte[7 - nb % 8]}};
            v[lane] = rx_byte[7 - nb % 8];
            hw_bit_clk <= 1'b0;
            hw_frame <= (nb == 0);
            rx_lanes <= v;
         end
         if (ph == 7) begin
            // tx is long settled here, well after the synchroniser delay
            e = int'(tx_bit !== gen_byte[7 - pos % 8]);
            tx_errs <= tx_errs + e;
            serr <= (pos % 8 == 7) ? 0 : serr + e;
            if (pos % 8 == 7 && serr + e > 1) begin
               multi <= multi + 1;
            end
         end
      end
   end
endmodule : tpcg_hw_model

// ---- verification/testbench.sv ----
// testbench: registers, checker window and tally, generator byte and error injection
`timescale 1ns/10ps
module testbench import tpcg_pkg::*;;
   // ==========================================================
   // signals
   localparam int FRAME_CYC = 32 * 8 * 8;
   logic ref_clk = 1'b0;
   logic rst = 1'b1;
   logic [7:0] host_addr = 8'h00;
   logic host_wr = 1'b0;
   logic host_rd = 1'b0;
   logic [7:0] host_wdata = 8'h00;
   logic hw_bit_clk;
   logic hw_frame;
   logic [31:0] rx_lanes;
   logic [7:0] host_rdata;
   logic tx_bit;
   logic inject_done;
   logic [4:0] lane = 5'h00;
   logic [7:0] rx_byte = 8'hFF;
   logic [7:0] gen_byte = 8'h00;
   logic [31:0] seed = 32'h027F;
   logic [7:0] reset_addrs [11] = '{8'h0A, 8'h0B, 8'h0C, 8'h0D, 8'h0E, 8'h0F, 8'h10,
      8'h11, 8'h12, 8'h1F, 8'h20};
   int tx_errs;
   int multi;
   int failures = 0;
   int n_checks = 0;
   initial begin
      forever #25 ref_clk = ~ref_clk;
   end
   tpcg_unit dut_u (.ref_clk(ref_clk), .rst(rst), .host_addr(host_addr), .host_wr(host_wr),
      .host_rd(host_rd), .host_wdata(host_wdata), .hw_bit_clk(hw_bit_clk),
      .hw_frame(hw_frame), .rx_lanes(rx_lanes), .host_rdata(host_rdata), .tx_bit(tx_bit),
      .inject_done(inject_done));
   tpcg_hw_model hw_u (.ref_clk(ref_clk), .rst(rst), .lane(lane), .rx_byte(rx_byte),
      .gen_byte(gen_byte), .tx_bit(tx_bit), .hw_bit_clk(hw_bit_clk), .hw_frame(hw_frame),
      .rx_lanes(rx_lanes), .tx_errs(tx_errs), .multi(multi));
   // ==========================================================
   // tasks
   function automatic logic [7:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed[7:0];
   endfunction : rnd
   task automatic stop_test();
      $display("checks %0d failures %0d", n_checks, failures);
      if (failures == 0 && n_checks > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask : stop_test
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      n_checks++;
      if (got !== exp) begin
         failures++;
         $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk
   // strobe low for one edge before the next task may raise it again
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      host_addr <= a;
      host_wdata <= d;
      host_wr <= 1'b1;
      @(posedge ref_clk);
      host_wr <= 1'b0;
      @(posedge ref_clk);
   endtask : wr
   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      host_addr <= a;
      host_rd <= 1'b1;
      @(posedge ref_clk);
      host_rd <= 1'b0;
      @(posedge ref_clk);
      @(negedge ref_clk);
      d = host_rdata;
      @(posedge ref_clk);
   endtask : rd
   task automatic wrrd(input logic [7:0] a, input logic [7:0] d, input logic [7:0] x);
      logic [7:0] v;
      wr(a, d);
      rd(a, v);
      chk(16'(v), 16'(x));
   endtask : wrrd
   // ==========================================================
   // watchdog
   initial begin
      repeat (90000) @(posedge ref_clk);
      failures++;
      stop_test();
   end
   // ==========================================================
   // main sequence
   initial begin : main
      logic [7:0] v;
      logic [7:0] lo_b;
      logic [7:0] hi_b;
      logic [7:0] r;
      logic [7:0] rb;
      logic [4:0] ln;
      int lo;
      int hi;
      int n;
      int e0;
      int m0;
      repeat (2) @(posedge ref_clk);
      rst <= 1'b0;
      @(posedge ref_clk);
      foreach (reset_addrs[i]) begin
         rd(reset_addrs[i], v);
         chk(16'(v), 16'h0000);
      end
      r = rnd();
      wrrd(OFS_CHK_LOW, r, {1'b0, r[6:0]});
      wrrd(OFS_CHK_HIGH, 8'hFF, 8'h7F);
      wrrd(OFS_CHK_REF, r, r);
      wrrd(OFS_TALLY_HI, r, 8'h00);
      for (int t = 0; t < 4; t++) begin
         lo = rnd() % 32;
         hi = (t == 1) ? 31 : lo + int'(rnd()) % (32 - lo);
         if (t == 1) begin
            lo = 0;
         end
         if (t == 0) begin
            hi = lo;
         end
         r = rnd();
         rb = (t == 1) ? ~r : rnd();
         ln = 5'(rnd());
         rx_byte <= rb;
         lane <= ln;
         wr(OFS_STYLE, 8'hFF);
         wr(OFS_LANE, 8'(ln));
         wr(OFS_CHK_HIGH, 8'(hi));
         wr(OFS_CHK_LOW, 8'(lo));
         wr(OFS_CHK_REF, r);
         repeat (FRAME_CYC) @(posedge ref_clk);
         // two low reads exactly one frame apart see every window bit once
         rd(OFS_TALLY_LO, v);
         repeat (FRAME_CYC - 3) @(posedge ref_clk);
         rd(OFS_TALLY_LO, lo_b);
         rd(OFS_TALLY_HI, hi_b);
         chk({hi_b, lo_b}, 16'((hi - lo + 1) * $countones(r ^ rb)));
      end
      r = rnd();
      gen_byte <= r;
      wrrd(OFS_GEN_BYTE, r, r);
      repeat (FRAME_CYC) @(posedge ref_clk);
      e0 = tx_errs;
      repeat (FRAME_CYC) @(posedge ref_clk);
      chk(16'(tx_errs - e0), 16'h0000);
      for (int k = 0; k < 2; k++) begin
         n = (k == 0) ? 1 + rnd() % 20 : 255;
         e0 = tx_errs;
         m0 = multi;
         wr(OFS_INJECT, 8'(n));
         for (int i = 0; i < n * 64 + 200 && inject_done !== 1'b1; i++) begin
            @(posedge ref_clk);
         end
         repeat (100) @(posedge ref_clk);
         chk(16'(inject_done), 16'h0001);
         rd(OFS_INJECT, v);
         chk(16'(v), 16'h0000);
         chk(16'(tx_errs - e0), 16'(n));
         chk(16'(multi - m0), 16'h0000);
         wr(OFS_STATUS, 8'h01);
         chk(16'(inject_done), 16'h0000);
      end
      stop_test();
   end
endmodule : testbench
